// ==== shared/fwd_map.svh ====
// Constants for the feed watchdog timer: keys, reset values and counts.
`ifndef FWD_MAP_SVH
`define FWD_MAP_SVH

// Width of the timeout counter and of its reload value.
`define FWD_CNT_W        32
// Peripheral-clock cycles per prescaled tick.
`define FWD_PRESCALE     4
// Width of the prescaler counter.
`define FWD_PRE_W        2
// Last prescaler count before a tick is issued.
`define FWD_PRE_LAST     2'h3
// Smallest reload value; a period is reload plus one ticks, so 256 ticks.
`define FWD_MIN_RELOAD   32'h000000FF
// Reload value after reset.
`define FWD_RELOAD_RST   32'h000000FF
// Width of a feed write.
`define FWD_FEED_W       8
// First and second key of a valid feed sequence.
`define FWD_FEED_KEY1    8'hAA
`define FWD_FEED_KEY2    8'h55

`endif

// ==== shared/fwd_pkg.sv ====
// Types shared by the feed watchdog timer modules.
`default_nettype none
`include "fwd_map.svh"

package fwd_pkg;

    // Progress through the two-write feed sequence.
    typedef enum logic [0:0] {
        FWD_FEED_IDLE = 1'b0,
        FWD_FEED_KEY1 = 1'b1
    } fwd_feed_st_t;

    // Control strobes and settings written by software.
    typedef struct packed {
        logic                     enable_set;
        logic                     reset_mode;
        logic                     reload_we;
        logic [`FWD_CNT_W-1:0]    reload_value;
        logic                     feed_we;
        logic [`FWD_FEED_W-1:0]   feed_data;
        logic                     other_we;
        logic                     timeout_clr;
        logic                     rst_flag_clr;
        logic                     debug_halt;
    } fwd_ctrl_t;

    // State that software can read back.
    typedef struct packed {
        logic                     enabled;
        logic                     timeout_flag;
        logic                     wd_reset_flag;
        logic                     feed_pending;
        logic [`FWD_CNT_W-1:0]    count;
    } fwd_stat_t;

endpackage : fwd_pkg

`default_nettype wire

// ==== src/fwd_prescale.sv ====
// Fixed divide-by-four prescaler that issues one-cycle tick enables.
`timescale 1ns/1ps
`default_nettype none
`include "fwd_map.svh"

module fwd_prescale (
    // Clock and reset.
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    // Control.
    input  wire logic clear_in,
    input  wire logic halt_in,
    // Tick enable.
    output logic      tick_out
);

    logic [`FWD_PRE_W-1:0] pre_reg;

    // Count peripheral clocks; a clear restarts a full prescaled period.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || clear_in) begin
            pre_reg <= '0;
        end else if (!halt_in) begin
            pre_reg <= pre_reg + `FWD_PRE_W'(1);
        end
    end

    // The tick is registered so the counter sees a clean one-cycle pulse.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || clear_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= !halt_in && (pre_reg == `FWD_PRE_LAST);
        end
    end

endmodule : fwd_prescale

`default_nettype wire

// ==== src/fwd_top.sv ====
// Feed watchdog timer: prescaled 32-bit countdown with keyed feed sequence.
//
// How it works
// RULE_01 - While enabled, an unfed expired interval raises a system reset in reset mode, or an interrupt otherwise.
// RULE_02 - Software may set the enable; only a reset or a firing clears it.
// RULE_03 - While enabled, a wrong or unfinished feed fires like a timeout.
// RULE_04 - A readable flag records that the watchdog caused a reset.
// RULE_05 - A 32-bit reload is counted down only on prescaler ticks.
// RULE_06 - The period is 256 to 2**32 ticks of four clock periods each.
// RULE_07 - Software feeds by writing two fixed keys in turn to the feed port.
`timescale 1ns/1ps
`default_nettype none
`include "fwd_map.svh"

module fwd_top (
    // Clock and reset.
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    // Software control.
    input  wire fwd_pkg::fwd_ctrl_t ctrl_in,
    // Status and actions.
    output var  fwd_pkg::fwd_stat_t status_out,
    output logic                   sys_reset_req_out,
    output logic                   irq_out
);

    // Clamp a reload so the period never drops below 256 ticks.
    function automatic logic [`FWD_CNT_W-1:0] fwd_clamp(
        input logic [`FWD_CNT_W-1:0] value
    );
        if (value < `FWD_MIN_RELOAD) begin
            fwd_clamp = `FWD_MIN_RELOAD;
        end else begin
            fwd_clamp = value;
        end
    endfunction : fwd_clamp

    logic [`FWD_CNT_W-1:0] reload_reg;
    logic [`FWD_CNT_W-1:0] count_reg;
    logic                  enabled_reg;
    logic                  timeout_flag_reg;
    logic                  wd_reset_flag_reg;
    logic                  irq_reg;
    logic                  reset_req_reg;
    fwd_pkg::fwd_feed_st_t feed_st_reg;
    fwd_pkg::fwd_feed_st_t feed_st_next;

    logic tick;
    logic feed_ok;
    logic feed_bad;
    logic expire;
    logic fire;
    logic enable_rise;
    logic restart;

    // Feed sequence decode: the first key arms, the second must follow.
    always_comb begin
        feed_ok      = 1'b0;
        feed_bad     = 1'b0;
        feed_st_next = feed_st_reg;
        case (feed_st_reg)
            fwd_pkg::FWD_FEED_IDLE: begin
                if (ctrl_in.feed_we) begin
                    if (ctrl_in.feed_data == `FWD_FEED_KEY1) begin
                        feed_st_next = fwd_pkg::FWD_FEED_KEY1; // [RULE_07]
                    end else begin
                        feed_bad = 1'b1; // [RULE_03]
                    end
                end
            end
            fwd_pkg::FWD_FEED_KEY1: begin
                // Any other access between the keys leaves the feed unfinished.
                if (ctrl_in.other_we) begin
                    feed_bad     = 1'b1; // [RULE_03]
                    feed_st_next = fwd_pkg::FWD_FEED_IDLE;
                end else if (ctrl_in.feed_we) begin
                    feed_st_next = fwd_pkg::FWD_FEED_IDLE;
                    if (ctrl_in.feed_data == `FWD_FEED_KEY2) begin
                        feed_ok = 1'b1; // [RULE_07]
                    end else begin
                        feed_bad = 1'b1; // [RULE_03]
                    end
                end
            end
            default: begin
                feed_st_next = fwd_pkg::FWD_FEED_IDLE;
            end
        endcase
    end

    // Expiry and failure events; nothing fires while disabled.
    assign expire      = enabled_reg && tick && (count_reg == '0); // [RULE_01]
    assign fire        = enabled_reg && (expire || feed_bad); // [RULE_03]
    assign enable_rise = ctrl_in.enable_set && !enabled_reg;
    assign restart     = fire || feed_ok || enable_rise;

    // The prescaler stalls while disabled or halted for debug.
    fwd_prescale u_prescale (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .clear_in   (restart),
        .halt_in    (!enabled_reg || ctrl_in.debug_halt),
        .tick_out   (tick)
    );

    // Feed sequence state.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            feed_st_reg <= fwd_pkg::FWD_FEED_IDLE;
        end else begin
            feed_st_reg <= feed_st_next;
        end
    end

    // Reload value; a new one only takes effect on the next restart.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            reload_reg <= `FWD_RELOAD_RST;
        end else if (ctrl_in.reload_we) begin
            reload_reg <= ctrl_in.reload_value; // [RULE_05]
        end
    end

    // Countdown: reload on restart, otherwise step once per tick.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            count_reg <= `FWD_RELOAD_RST;
        end else if (restart) begin
            count_reg <= fwd_clamp(reload_reg); // [RULE_06]
        end else if (enabled_reg && tick) begin
            count_reg <= count_reg - `FWD_CNT_W'(1); // [RULE_05]
        end
    end

    // Enable is set-only from software; only a firing or a reset turns it back off.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            enabled_reg <= 1'b0;
        end else if (fire) begin
            enabled_reg <= 1'b0; // [RULE_02]
        end else if (ctrl_in.enable_set) begin
            enabled_reg <= 1'b1; // [RULE_02]
        end
    end

    // Timeout flag records every firing; a new firing beats a clear.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            timeout_flag_reg <= 1'b0;
        end else if (fire) begin
            timeout_flag_reg <= 1'b1;
        end else if (ctrl_in.timeout_clr) begin
            timeout_flag_reg <= 1'b0;
        end
    end

    // Interrupt level in interrupt mode, cleared with the timeout flag.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_reg <= 1'b0;
        end else if (fire && !ctrl_in.reset_mode) begin
            irq_reg <= 1'b1; // [RULE_03]
        end else if (ctrl_in.timeout_clr) begin
            irq_reg <= 1'b0;
        end
    end

    // One-cycle reset request; rst_n_in resets this block,
    // and it resets the cause flag below in the same way.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            reset_req_reg <= 1'b0;
        end else begin
            reset_req_reg <= fire && ctrl_in.reset_mode; // [RULE_01]
        end
    end

    // Reset cause flag; set wins over a software clear in the same cycle.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wd_reset_flag_reg <= 1'b0;
        end else if (fire && ctrl_in.reset_mode) begin
            wd_reset_flag_reg <= 1'b1; // [RULE_04]
        end else if (ctrl_in.rst_flag_clr) begin
            wd_reset_flag_reg <= 1'b0;
        end
    end

    // Outputs come straight from registers.
    assign sys_reset_req_out        = reset_req_reg;
    assign irq_out                  = irq_reg;
    assign status_out.enabled       = enabled_reg;
    assign status_out.timeout_flag  = timeout_flag_reg;
    assign status_out.wd_reset_flag = wd_reset_flag_reg; // [RULE_04]
    assign status_out.feed_pending  = (feed_st_reg == fwd_pkg::FWD_FEED_KEY1);
    assign status_out.count         = count_reg;

endmodule : fwd_top

`default_nettype wire

// ==== verification/fwd_top_asserts.sv ====
// Port checks for the feed watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "fwd_map.svh"

module fwd_top_asserts (
    // Clock and reset.
    input wire logic               sys_clk_in,
    input wire logic               rst_n_in,
    // Watched ports.
    input wire fwd_pkg::fwd_ctrl_t ctrl_in,
    input wire fwd_pkg::fwd_stat_t status_out,
    input wire logic               sys_reset_req_out,
    input wire logic               irq_out
);
    // One clock domain, so the clock and reset are given once.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_ENABLE_SET: assert property (
        ctrl_in.enable_set && !status_out.enabled |=> status_out.enabled)
        else $error("enable request ignored");
    AST_NO_SW_CLEAR: assert property (
        $past(rst_n_in) && $fell(status_out.enabled) |->
        status_out.timeout_flag) else $error("enable dropped without firing");
    AST_FIRE_ENABLED: assert property (
        $rose(status_out.timeout_flag) |-> $past(status_out.enabled))
        else $error("fired while disabled");
    AST_FIRE_ACTION: assert property (
        $rose(status_out.timeout_flag) |-> ($past(ctrl_in.reset_mode) ?
        sys_reset_req_out && status_out.wd_reset_flag :
        irq_out && !sys_reset_req_out)) else $error("wrong firing action");
    AST_REQ_PULSE: assert property (
        sys_reset_req_out |=> !sys_reset_req_out)
        else $error("reset request longer than one cycle");
    AST_REQ_FLAG: assert property (
        sys_reset_req_out |-> status_out.wd_reset_flag && !status_out.enabled)
        else $error("reset request without flag");
    AST_BAD_FEED: assert property (
        status_out.enabled && ((ctrl_in.feed_we && !status_out.feed_pending &&
        ctrl_in.feed_data != `FWD_FEED_KEY1) || (status_out.feed_pending &&
        (ctrl_in.other_we || (ctrl_in.feed_we &&
        ctrl_in.feed_data != `FWD_FEED_KEY2)))) |=>
        status_out.timeout_flag && !status_out.enabled)
        else $error("bad feed did not fire");
    AST_GOOD_FEED: assert property (
        status_out.enabled && status_out.feed_pending && ctrl_in.feed_we &&
        !ctrl_in.other_we && ctrl_in.feed_data == `FWD_FEED_KEY2 &&
        status_out.count != 32'h0 |=>
        !status_out.feed_pending && status_out.enabled)
        else $error("valid feed not accepted");
    // A decrement is a tick; the next cycle cannot be another tick.
    AST_TICK_GAP: assert property (
        status_out.enabled && $past(status_out.enabled) &&
        status_out.count == $past(status_out.count) - 32'h1 &&
        !ctrl_in.feed_we && !ctrl_in.other_we |=> $stable(status_out.count))
        else $error("count moved between ticks");

    // Main scenarios reached.
    cover property (sys_reset_req_out);
    cover property ($rose(irq_out));
    cover property (status_out.feed_pending ##1 !status_out.feed_pending);
endmodule : fwd_top_asserts

`default_nettype wire

// ==== verification/fwd_top_tb.sv ====
// Directed bench for the feed watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "fwd_map.svh"

module fwd_top_tb;
    // Strobe selectors for op: enable, feed, other, clear, reload.
    localparam logic [4:0] EN = 5'h10, FD = 5'h08, OT = 5'h04;
    localparam logic [4:0] CL = 5'h02, RL = 5'h01;
    logic               clk     = 1'b0;
    logic               rst_n   = 1'b0;
    fwd_pkg::fwd_ctrl_t ctrl    = '0;
    fwd_pkg::fwd_stat_t stat;
    logic               req;
    logic               irq;
    int                 fails   = 0;
    int                 n_tests = 0;

    // 200 MHz clock.
    always #2.5 clk = ~clk;

    fwd_top i_fwd_top (.sys_clk_in(clk), .rst_n_in(rst_n), .ctrl_in(ctrl),
        .status_out(stat), .sys_reset_req_out(req), .irq_out(irq));

    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    // One cycle of strobes; clear and flag clear travel together.
    task automatic op(input logic [4:0] f, input logic [7:0] d);
        @(posedge clk);
        {ctrl.enable_set, ctrl.feed_we, ctrl.other_we, ctrl.timeout_clr,
         ctrl.rst_flag_clr, ctrl.reload_we} <= {f[4:1], f[1], f[0]};
        ctrl.feed_data <= d;
        @(posedge clk);
        {ctrl.enable_set, ctrl.feed_we, ctrl.other_we, ctrl.timeout_clr,
         ctrl.rst_flag_clr, ctrl.reload_we} <= 6'h00;
    endtask : op

    task automatic hw_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
    endtask : hw_reset

    task automatic t_reset();
        chk("count", 32'hFF, stat.count);
        chk("wd_flag", 32'h0, stat.wd_reset_flag);
        op(EN, 8'h00);
        @(negedge clk);
        chk("enabled", 32'h1, stat.enabled);
        hw_reset();
        chk("enabled", 32'h0, stat.enabled);
    endtask : t_reset

    // Lets the interval run out; lo is the expected period in clocks, at four clocks per tick.
    task automatic t_timeout(input logic m, input logic [31:0] r,
                             input int lo);
        int n;
        @(posedge clk);
        ctrl.reset_mode <= m;
        ctrl.reload_value <= r;
        op(RL, 8'h00);
        op(EN, 8'h00);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (stat.timeout_flag !== 1'b1 && n < 3000);
        chk("period", 32'h1, 32'(n >= lo && n <= lo + 2));
        chk("enabled", 32'h0, stat.enabled);
        chk("reset_req", m, req);
        chk("irq", !m, irq);
        chk("wd_flag", m, stat.wd_reset_flag);
        op(CL, 8'h00);
        @(negedge clk);
        chk("wd_flag", 32'h0, stat.wd_reset_flag);
        chk("irq_clr", 32'h0, irq);
        chk("flag_clr", 32'h0, stat.timeout_flag);
    endtask : t_timeout

    // A feed in mid-interval restarts it; total wait exceeds one period.
    task automatic t_feed();
        op(EN, 8'h00);
        repeat (700) @(posedge clk);
        op(FD, `FWD_FEED_KEY1);
        @(negedge clk);
        chk("pending", 32'h1, stat.feed_pending);
        op(FD, `FWD_FEED_KEY2);
        @(negedge clk);
        chk("pending", 32'h0, stat.feed_pending);
        chk("count", 32'h100, stat.count);
        // Debug halt must freeze the countdown, or a probe stop would fire.
        @(posedge clk);
        ctrl.debug_halt <= 1'b1;
        repeat (20) @(posedge clk);
        ctrl.debug_halt <= 1'b0;
        @(negedge clk);
        chk("halt_count", 32'h100, stat.count);
        op(EN, 8'h00);
        repeat (700) @(posedge clk);
        @(negedge clk);
        chk("fired", 32'h0, stat.timeout_flag);
        chk("enabled", 32'h1, stat.enabled);
        hw_reset();
    endtask : t_feed

    // Wrong first key, other access, repeated first key, wrong second key.
    task automatic t_bad();
        logic [7:0] k1 [4] = '{8'h55, 8'hAA, 8'hAA, 8'hAA};
        logic [7:0] k2 [4] = '{8'h00, 8'h00, 8'hAA, 8'h00};
        for (int i = 0; i < 4; i++) begin
            op(EN, 8'h00);
            op(FD, k1[i]);
            if (i > 0) begin
                op(i == 1 ? OT : FD, k2[i]);
            end
            @(negedge clk);
            chk("bad_feed", 32'h1, stat.timeout_flag);
            chk("bad_off", 32'h0, stat.enabled);
            op(CL, 8'h00);
        end
        op(FD, 8'h55);
        @(negedge clk);
        chk("idle_feed", 32'h0, stat.timeout_flag);
    endtask : t_bad

    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // Main sequence after twelve cycles of reset.
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset();
        t_timeout(1'b1, 32'h0, 1024);
        t_timeout(1'b0, 32'h100, 1028);
        t_feed();
        t_bad();
        print_verdict();
    end

    // The sequence needs about 3600 cycles; this cuts off a hang.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end
endmodule : fwd_top_tb

bind fwd_top fwd_top_asserts i_fwd_top_asserts (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .ctrl_in(ctrl_in), .status_out(status_out),
    .sys_reset_req_out(sys_reset_req_out), .irq_out(irq_out));

`default_nettype wire
